// ===== hdl/urx_rx_error_irq_wake.v
`timescale 1ns/10ps
`include "urx_consts.vh"

// Notes on behaviour
// [R01] Overrun clears by status then data read
// [R02] Noise flag rises with data-available, word kept
// [R03] Noise alone requests no interrupt
// [R04] Noise clears by status then data read; the code clears it with its word on any data read
// [R05] Low stop bit sets framing error
// [R06] Error flags stored per word, reset clears
// [R07] Parity mismatch flagged only when enabled
// [R08] Software reads errors before the data
// [R09] Six sources request low interrupt pulse
// [R10] Vector only with enables, stack free
// [R11] Two tx enables, one shared rx enable
// [R12] Address detect interrupts without a flag
// [R13] Falling RX wakes when clock off, enabled
// [R14] Flags read-only, cleared by sequences only; PERR, FERR and NF clear with their word on any data read
// [R15] Address mode needs highest bit set
// [R16] No address mode: every word interrupts
// [R17] Software keeps parity off in address mode
// [R18] Transmit pauses while clock stopped
// [R19] Reception pauses in idle or sleep
// [R20] Power-down leaves registers unchanged
// [R21] RX ignored during wake start-up
// [R22] Wake interrupt only enabled, after start-up
// [R23] Data flag while buffer holds a word
// [R24] Third word dropped, overrun set
module urx_rx_error_irq_wake
(
   // Clock and reset
   input wire mclk,
   input wire reset,
   // Register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Serial line and transmitter status
   input wire rx_pin,
   input wire bit_tick16,
   input wire tx_buf_empty,
   input wire tx_idle,
   // System side
   output reg irq_n,
   output reg vector_req,
   output reg wake_req
);

   // ***************************************************
   // Registers
   // ***************************************************
   reg [7:0] ctrl1_q;
   reg [7:0] ctrl2_q;
   reg [7:0] power_q;
   reg status_seen_q;
   reg oerr_q;
   reg starting_q;
   reg [15:0] start_cnt_q;
   reg wake_pend_q;

   wire clk_on = power_q[`URX_PW_CLKON];
   wire nine = ctrl1_q[`URX_C1_NINE];
   wire rx_on = ctrl1_q[`URX_C1_MODE] & ctrl1_q[`URX_C1_PORTEN] &
                ctrl2_q[`URX_C2_RXEN];
   // Module clock gating pauses the receiver and frame state  [R18] [R19]
   wire run = clk_on & ~starting_q & bit_tick16;

   // ***************************************************
   // Receiver: 16x oversampled, majority of three
   // ***************************************************
   localparam S_IDLE = 2'd0;
   localparam S_DATA = 2'd1;
   localparam S_STOP = 2'd2;
   reg [1:0] state_q;
   reg [3:0] ph_q;
   reg [3:0] nbit_q;
   reg [9:0] shf_q;
   reg [2:0] smp_q;
   reg noise_q;
   reg par_q;
   reg stop2nd_q;
   reg ferr_acc_q;
   wire maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) |
              (smp_q[1] & smp_q[2]);
   wire disagree = ~(smp_q[0] == smp_q[1] && smp_q[1] == smp_q[2]);
   wire [3:0] nbits = nine ? 4'd9 : 4'd8;
   reg done;
   reg [10:0] done_word;

   always @(posedge mclk)
   begin
      done <= 1'b0;
      if (reset)
      begin
         state_q <= S_IDLE;
         ph_q <= 4'h0;
         nbit_q <= 4'h0;
         shf_q <= 10'h000;
         smp_q <= 3'h7;
         noise_q <= 1'b0;
         par_q <= 1'b0;
         stop2nd_q <= 1'b0;
         ferr_acc_q <= 1'b0;
         done_word <= 11'h000;
      end
      else if (run & rx_on)
      begin
         smp_q <= {smp_q[1:0], rx_pin};
         ph_q <= ph_q + 4'h1;
         case (state_q)
            S_IDLE:
            begin
               ph_q <= 4'h0;
               // Needs a high sample first: a low stop bit is no start
               if (!rx_pin && smp_q[0])
               begin
                  state_q <= S_DATA;
                  nbit_q <= 4'h0;
                  noise_q <= 1'b0;
                  par_q <= 1'b0;
                  ph_q <= 4'h8;
                  stop2nd_q <= 1'b0;
                  ferr_acc_q <= 1'b0;
               end
            end
            S_DATA:
               if (ph_q == 4'hf)
               begin
                  if (disagree)
                     noise_q <= 1'b1;
                  if (nbit_q != 4'h0)
                  begin
                     shf_q <= {maj, shf_q[9:1]};
                     par_q <= par_q ^ maj;
                  end
                  // Start, data bits, then optional parity
                  if (nbit_q == nbits + {3'h0, ctrl1_q[`URX_C1_PREN]})
                     state_q <= S_STOP;
                  nbit_q <= nbit_q + 4'h1;
               end
            S_STOP:
               if (ph_q == 4'hf)
               begin
                  if (disagree)
                     noise_q <= 1'b1;
                  if (ctrl1_q[`URX_C1_STOP2] && !stop2nd_q)
                  begin
                     stop2nd_q <= 1'b1;
                     ferr_acc_q <= ~maj;
                  end
                  else
                  begin
                     done <= 1'b1;
                     state_q <= S_IDLE;
                     // Either stop bit low is a framing error  [R05]
                     done_word[10] <= ferr_acc_q | ~maj;
                     // Parity bit folded in: even sum ok, odd sum ok with URX_C1_PODD  [R07]
                     done_word[9] <= ctrl1_q[`URX_C1_PREN] &
                        ((par_q ^ ctrl1_q[`URX_C1_PODD]) != 1'b0);
                     // Parity, when on, is the last bit shifted in
                     done_word[8:0] <= ctrl1_q[`URX_C1_PREN] ?
                        (nine ? shf_q[8:0] : {1'b0, shf_q[8:1]}) :
                        (nine ? shf_q[9:1] : {1'b0, shf_q[9:2]});
                  end
               end
            default:
               state_q <= S_IDLE;
         endcase
      end
      else if (!rx_on)
         state_q <= S_IDLE;
   end

   // ***************************************************
   // Two-entry buffer with per-word error flags
   // ***************************************************
   reg [11:0] buf_q [0:1];
   reg [1:0] cnt_q;
   wire [11:0] head = buf_q[0];
   wire rd_data = reg_rd && reg_addr == `URX_OFS_DATA;
   wire rd_stat = reg_rd && reg_addr == `URX_OFS_STATUS;
   wire pop = rd_data && cnt_q != 2'd0;
   wire push = done && (cnt_q != 2'd2 || pop);
   wire dropped = done && cnt_q == 2'd2 && !pop;
   wire seq_clear = rd_data && status_seen_q;
   wire rxif = cnt_q != 2'd0; // [R23]
   wire hi_bit = nine ? done_word[8] : done_word[7];

   always @(posedge mclk)
   begin
      if (reset)
      begin
         buf_q[0] <= 12'h000;
         buf_q[1] <= 12'h000;
         cnt_q <= 2'd0;
         status_seen_q <= 1'b0;
         oerr_q <= 1'b0;
      end
      else
      begin
         // Flags and word travel together  [R06] [R02]
         if (pop)
         begin
            buf_q[0] <= (cnt_q == 2'd2) ? buf_q[1] : {noise_q, done_word};
            if (push)
               buf_q[cnt_q == 2'd2 ? 1'b1 : 1'b0] <= {noise_q, done_word};
         end
         else if (push)
            buf_q[cnt_q[0]] <= {noise_q, done_word};
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
         if (rd_stat)
            status_seen_q <= 1'b1;
         else if (reg_rd || reg_wr)
            status_seen_q <= 1'b0;
         // Third word dropped; set beats clear  [R24] [R01] [R14]
         if (dropped)
            oerr_q <= 1'b1;
         else if (seq_clear)
            oerr_q <= 1'b0;
      end
   end

   // ***************************************************
   // Interrupt sources and wake-up
   // ***************************************************
   wire rie = ctrl2_q[`URX_C2_RIE];
   wire gate = power_q[`URX_PW_GIE] & power_q[`URX_PW_MIE] &
               ~power_q[`URX_PW_STKFULL];
   // Noise never contributes; address mode needs top bit  [R03] [R15] [R16]
   wire rx_evt = push & rie & (~ctrl2_q[`URX_C2_ADDEN] | hi_bit);
   wire addr_evt = push & ctrl2_q[`URX_C2_ADDEN] & hi_bit; // [R12]
   wire txe_rise;
   wire txi_rise;
   wire rx_fall;
   wire tx_evt = (txe_rise & ctrl2_q[`URX_C2_TEIE]) |
                 (txi_rise & ctrl2_q[`URX_C2_TIIE]); // [R11]
   wire wake_ok = ~clk_on & ctrl2_q[`URX_C2_WAKE] & rx_on & rie;
   // One wake per power-down: later edges fall in the start-up
   wire wake_hit = wake_ok & rx_fall & ~starting_q; // [R13]
   localparam integer START_I = `URX_START_CYC;
   wire any_evt = rx_evt | addr_evt | (dropped & rie) | tx_evt |
                  (wake_pend_q & ~starting_q & clk_on); // [R09]

   urx_edge_det #(.RISE(1), .IDLE(1'b1)) txe_det
   (
      .mclk(mclk),
      .reset(reset),
      .level(tx_buf_empty),
      .hit(txe_rise)
   );

   urx_edge_det #(.RISE(1), .IDLE(1'b1)) txi_det
   (
      .mclk(mclk),
      .reset(reset),
      .level(tx_idle),
      .hit(txi_rise)
   );

   urx_edge_det #(.RISE(0), .IDLE(1'b1)) rxf_det
   (
      .mclk(mclk),
      .reset(reset),
      .level(rx_pin),
      .hit(rx_fall)
   );

   always @(posedge mclk)
   begin
      if (reset)
      begin
         irq_n <= 1'b1;
         vector_req <= 1'b0;
         wake_req <= 1'b0;
         wake_pend_q <= 1'b0;
         starting_q <= 1'b0;
         start_cnt_q <= 16'h0000;
      end
      else
      begin
         irq_n <= ~any_evt;
         vector_req <= any_evt & gate; // [R10]
         wake_req <= 1'b0;
         if (wake_hit)
         begin
            wake_req <= 1'b1; // [R13]
            wake_pend_q <= gate; // [R22]
         end
         else if (wake_pend_q && !starting_q && clk_on)
            wake_pend_q <= 1'b0;
         // Start-up interval masks the receiver  [R21]
         if (wake_hit)
         begin
            starting_q <= 1'b1;
            start_cnt_q <= START_I[15:0];
         end
         else if (starting_q && clk_on)
         begin
            if (start_cnt_q == 16'h0001)
               starting_q <= 1'b0;
            start_cnt_q <= start_cnt_q - 16'h0001;
         end
      end
   end

   // ***************************************************
   // Register port; sleep does not touch these  [R20]
   // ***************************************************
   always @(posedge mclk)
   begin
      if (reset)
      begin
         ctrl1_q <= `URX_CTRL_RST;
         ctrl2_q <= `URX_CTRL_RST;
         power_q <= `URX_PW_RST;
         reg_rdata <= 8'h00;
      end
      else
      begin
         if (reg_wr)
            case (reg_addr)
               `URX_OFS_CTRL1: ctrl1_q <= {reg_wdata[7:2], 1'b0,
                                           reg_wdata[0]};
               `URX_OFS_CTRL2: ctrl2_q <= reg_wdata;
               `URX_OFS_POWER: power_q <= reg_wdata;
               default: ;
            endcase
         reg_rdata <= 8'h00;
         if (reg_rd)
            case (reg_addr)
               // Status is read-only; noise clears with its word  [R04]
               `URX_OFS_STATUS: reg_rdata <= {tx_buf_empty, tx_idle, rxif,
                  state_q == S_IDLE, oerr_q, head[10] & rxif,
                  head[11] & rxif, head[9] & rxif}; // [R14]
               `URX_OFS_CTRL1: reg_rdata <= {ctrl1_q[7:2], head[8],
                                             ctrl1_q[0]};
               `URX_OFS_CTRL2: reg_rdata <= ctrl2_q;
               `URX_OFS_DATA: reg_rdata <= head[7:0];
               `URX_OFS_POWER: reg_rdata <= power_q;
               default: reg_rdata <= 8'h00;
            endcase
      end
   end
endmodule // urx_rx_error_irq_wake

// ***************************************************
// Edge detector for level inputs
// ***************************************************
module urx_edge_det
#(
   parameter integer RISE = 1,
   parameter [0:0] IDLE = 1'b0
)
(
   // Clock and reset
   input wire mclk,
   input wire reset,
   // Level in, one-cycle edge out
   input wire level,
   output wire hit
);

   reg prev_q;

   // Reset to the idle level so no false edge follows reset
   always @(posedge mclk)
   begin
      if (reset)
         prev_q <= IDLE;
      else
         prev_q <= level;
   end

   assign hit = (RISE != 0) ? (level & ~prev_q) : (~level & prev_q);
endmodule // urx_edge_det

// ===== hdl/urx_consts.vh
`ifndef URX_CONSTS_VH
`define URX_CONSTS_VH
// Register offsets
`define URX_OFS_STATUS 4'h0
`define URX_OFS_CTRL1 4'h1
`define URX_OFS_CTRL2 4'h2
`define URX_OFS_DATA 4'h3
`define URX_OFS_POWER 4'h4
// Status bits
`define URX_ST_PERR 0
`define URX_ST_NF 1
`define URX_ST_FERR 2
`define URX_ST_OERR 3
`define URX_ST_RIDLE 4
`define URX_ST_RXIF 5
`define URX_ST_TIDLE 6
`define URX_ST_TXIF 7
// Control one bits
`define URX_C1_MODE 7
`define URX_C1_PORTEN 6
`define URX_C1_NINE 5
`define URX_C1_PREN 4
`define URX_C1_PODD 3
`define URX_C1_STOP2 2
`define URX_C1_RX8 1
// Control two bits
`define URX_C2_RXEN 6
`define URX_C2_ADDEN 5
`define URX_C2_WAKE 4
`define URX_C2_RIE 3
`define URX_C2_TIIE 2
`define URX_C2_TEIE 1
// Power register bits
`define URX_PW_CLKON 0
`define URX_PW_GIE 1
`define URX_PW_MIE 2
`define URX_PW_STKFULL 3
// Reset values
`define URX_CTRL_RST 8'h00
`define URX_PW_RST 8'h01
// Timing
`define URX_OVS 16
`define URX_START_NS 1000
`define URX_MCLK_MHZ 250
`define URX_START_CYC ((`URX_START_NS*`URX_MCLK_MHZ+999)/1000)
`define URX_IRQ_LOW 1
`endif

// ===== testbench/urx_rx_error_irq_wake_properties.sv
`timescale 1ns/10ps
`include "urx_consts.vh"
module urx_chk
(
   // Clock and reset
   input wire mclk,
   input wire reset,
   // Register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // Line and transmitter status
   input wire rx_pin,
   input wire bit_tick16,
   input wire tx_buf_empty,
   input wire tx_idle,
   // System side
   input wire irq_n,
   input wire vector_req,
   input wire wake_req
);
   // ****************
   // Start-up window
   // ****************
   // Two cycles short so a one-cycle skew in the count cannot misfire
   reg [9:0] wake_q;
   always @(posedge mclk)
   begin
      if (reset)
         wake_q <= 10'h000;
      else if (wake_req)
         wake_q <= 10'(`URX_START_CYC - 2);
      else if (wake_q != 10'h000)
         wake_q <= wake_q - 10'h001;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence unmapped_rd;
      reg_rd && reg_addr > 4'h4;
   endsequence
   irq_pulse_a: assert property (!irq_n |=> irq_n)
      else $error("irq_n low for more than one cycle");
   vector_irq_a: assert property (vector_req |-> !irq_n)
      else $error("vector without interrupt pulse");
   vector_once_a: assert property (vector_req |=> !vector_req)
      else $error("vector request longer than one cycle");
   wake_once_a: assert property (wake_req |=> !wake_req)
      else $error("wake request longer than one cycle");
   startup_quiet_a: assert property (wake_q != 10'h000 |-> irq_n)
      else $error("interrupt inside start-up interval");
   reset_out_a: assert property
      ($past(reset) |-> irq_n && !vector_req && !wake_req)
      else $error("outputs not at reset values");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside answer cycle");
   unmapped_rd_a: assert property (unmapped_rd |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule // urx_chk
bind urx_rx_error_irq_wake urx_chk chk (.mclk(mclk), .reset(reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin),
   .bit_tick16(bit_tick16), .tx_buf_empty(tx_buf_empty),
   .tx_idle(tx_idle), .irq_n(irq_n), .vector_req(vector_req),
   .wake_req(wake_req));

// ===== testbench/urx_tx_model.sv
`timescale 1ns/10ps
`include "urx_consts.vh"
module urx_tx_model
(
   // Clock and baud pulses
   input wire mclk,
   input wire bit_tick16,
   // Serial line, idle high
   output reg line
);
   // ****************
   // Frame sender
   // ****************
   initial line = 1'b1;
   task hold;
      integer i;
      begin
         i = 0;
         while (i < `URX_OVS)
         begin
            @(posedge mclk);
            if (bit_tick16)
               i = i + 1;
         end
      end
   endtask
   // Start, data LSB first, optional parity, one stop
   task send(input [7:0] d, input use_p, input p, input bad);
      integer k;
      begin
         line <= 1'b0;
         hold;
         for (k = 0; k < 8; k = k + 1)
         begin
            line <= d[k];
            hold;
         end
         if (use_p)
         begin
            line <= p;
            hold;
         end
         line <= ~bad;
         hold;
         line <= 1'b1;
         @(posedge mclk);
      end
   endtask
endmodule // urx_tx_model

// ===== testbench/test_urx_rx_error_irq_wake.sv
`timescale 1ns/10ps
`include "urx_consts.vh"
module test_urx_rx_error_irq_wake;
   reg mclk, reset, reg_wr, reg_rd, bit_tick16, tx_buf_empty, tx_idle;
   reg [3:0] reg_addr;
   reg [7:0] reg_wdata, st, dt;
   wire [7:0] reg_rdata;
   wire rx_pin, irq_n, vector_req, wake_req;
   integer num_errors, checked, irq_c, vec_c, wake_c, cyc, n, p;
   urx_rx_error_irq_wake DUT (.mclk(mclk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin),
      .bit_tick16(bit_tick16), .tx_buf_empty(tx_buf_empty),
      .tx_idle(tx_idle), .irq_n(irq_n), .vector_req(vector_req),
      .wake_req(wake_req));
   urx_tx_model tx (.mclk(mclk), .bit_tick16(bit_tick16), .line(rx_pin));
   // ****************
   // Clock, pulses, counts
   // ****************
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      bit_tick16 <= ~bit_tick16;
      cyc = cyc + 1;
      if (!reset && irq_n === 1'b0)
         irq_c = irq_c + 1;
      if (!reset && vector_req === 1'b1)
         vec_c = vec_c + 1;
      if (!reset && wake_req === 1'b1)
         wake_c = wake_c + 1;
      if (cyc == 20000)
      begin
         num_errors = num_errors + 1;
         finish_test;
      end
   end
   task wr(input [3:0] a, input [7:0] d);
      begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge mclk);
         reg_wr <= 1'b0;
         @(posedge mclk);
      end
   endtask
   task rd(input [3:0] a, output [7:0] d);
      begin
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge mclk);
         reg_rd <= 1'b0;
         @(negedge mclk);
         d = reg_rdata;
         @(posedge mclk);
      end
   endtask
   task chk(input [7:0] g, input [7:0] e);
      begin
         checked = checked + 1;
         if (g !== e)
         begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: got %h, expected %h", $time, g, e);
         end
      end
   endtask
   // Status first, then data, as one clearing sequence
   task get(input [7:0] d, input use_p, input p, input bad);
      begin
         tx.send(d, use_p, p, bad);
         repeat (40) @(posedge mclk);
         rd(4'h0, st);
         rd(4'h3, dt);
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d, errors %0d", checked, num_errors);
         if (num_errors == 0 && checked > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // ****************
   // Tests
   // ****************
   initial
   begin
      {reg_wr, reg_rd, bit_tick16, tx_buf_empty, tx_idle} = 5'h00;
      {reg_addr, reg_wdata} = 12'h000;
      {num_errors, checked, irq_c, vec_c, wake_c, cyc} = 0;
      reset = 1'b1;
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      rd(4'h4, dt);
      chk(dt, `URX_PW_RST);
      rd(4'h9, dt);
      chk(dt, 8'h00);
      wr(4'h0, 8'hFF);
      rd(4'h0, st);
      chk(st & 8'h2F, 8'h00);
      $display("test registers done");
      wr(4'h1, 8'hC0);
      wr(4'h2, 8'h48);
      get(8'hA5, 0, 0, 0);
      chk(st & 8'h2F, 8'h20);
      chk(dt, 8'hA5);
      chk(irq_c, 1);
      chk(vec_c, 0);
      get(8'h3C, 0, 0, 1);
      chk(st & 8'h2F, 8'h24);
      chk(dt, 8'h3C);
      wr(4'h1, 8'hD0);
      for (p = 0; p < 2; p = p + 1)
      begin
         get(8'h3C, 1, p, 0);
         chk(st & 8'h2F, 8'h20 | p);
         chk(dt, 8'h3C);
      end
      wr(4'h1, 8'hC0);
      $display("test errors done");
      tx.send(8'h11, 0, 0, 0);
      tx.send(8'h22, 0, 0, 0);
      get(8'h33, 0, 0, 0);
      chk(st & 8'h28, 8'h28);
      chk(dt, 8'h11);
      rd(4'h0, st);
      chk(st & 8'h28, 8'h20);
      rd(4'h3, dt);
      chk(dt, 8'h22);
      $display("test overrun done");
      wr(4'h4, 8'h07);
      wr(4'h2, 8'h68);
      n = irq_c;
      get(8'h05, 0, 0, 0);
      chk(irq_c - n, 0);
      get(8'h85, 0, 0, 0);
      chk(irq_c != n, 1);
      chk(vec_c != 0, 1);
      wr(4'h2, 8'h06);
      n = irq_c;
      tx_buf_empty <= 1'b1;
      repeat (4) @(posedge mclk);
      tx_idle <= 1'b1;
      repeat (4) @(posedge mclk);
      chk(irq_c - n, 2);
      $display("test interrupts done");
      wr(4'h2, 8'h58);
      wr(4'h4, 8'h06);
      tx.send(8'h5A, 0, 0, 0);
      repeat (300) @(posedge mclk);
      chk(wake_c, 1);
      n = irq_c;
      wr(4'h4, 8'h07);
      repeat (100) @(posedge mclk);
      chk(irq_c - n, 0);
      repeat (200) @(posedge mclk);
      chk(irq_c - n, 1);
      $display("test wake done");
      finish_test;
   end
endmodule // test_urx_rx_error_irq_wake
